// ===== hdl/eqac_top.sv
/*
 * Equalizer adaptation control: APB registers, input synchronisers,
 * adaptation sequencer and reported lock for one receive port.
 * Assumes an APB master on pclk, a lock detector level and a remote
 * self-test level arriving from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eqac_regs.svh"

module eqac_top #(
    parameter int unsigned WAIT_BASE_CYCLES = `EQAC_WAIT_BASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_lock_raw,
    input wire logic remote_selftest_raw,
    output logic [5:0] eq_setting,
    output logic rx_lock_reported,
    output logic adapt_done
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************

    // A zero base would make one step run the whole counter range
    initial begin
        if (WAIT_BASE_CYCLES < 1) begin
            $error("eqac_top: WAIT_BASE_CYCLES must be at least one");
        end
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    eqac_pkg::eqac_top_state_type r_reg;   // All state
    eqac_pkg::eqac_top_state_type r_next;  // Next state
    eqac_tmr_if tif ();                    // Timer carrier
    logic setup;                           // APB setup cycle
    logic wr_take;                         // Write takes effect
    logic mapped;                          // Address hits a register
    logic lock_now;                        // Accepted lock level
    logic selftest_now;                    // Accepted self-test level
    logic [5:0] start_value;               // Adaptive starting setting
    logic [5:0] cap_value;                 // Adaptive ceiling

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // True when the byte address selects register index idx
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr == {2'b00, idx, 2'b00});
    endfunction : hit

    // Unmapped addresses answer with an error
    always_comb begin
        mapped = hit(paddr, `EQAC_IDX_DEBUG) || hit(paddr, `EQAC_IDX_CTL2) ||
                 hit(paddr, `EQAC_IDX_STATUS) || hit(paddr, `EQAC_IDX_BYPASS) ||
                 hit(paddr, `EQAC_IDX_MINMAX);
    end

    // ****************************************************************
    // Bus handshake
    // ****************************************************************

    // Read data is captured in setup, so access never needs a wait
    assign setup = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign wr_take = psel && penable && pwrite && mapped;
    assign prdata = r_reg.prdata;

    // ****************************************************************
    // Derived values
    // ****************************************************************
    assign lock_now = r_reg.filt[0];
    assign selftest_now = r_reg.filt[1];
    assign cap_value = {2'b00, r_reg.cap};

    // Floor or zero, never above the ceiling
    always_comb begin
        start_value = 6'h00;
        if (r_reg.floor_en && !r_reg.zero_start) begin
            start_value = {2'b00, r_reg.floor_val};
        end
        if (start_value > cap_value) begin
            start_value = cap_value;
        end
    end

    // ****************************************************************
    // Step timer
    // ****************************************************************

    // Timer runs only while waiting for lock
    assign tif.hold = (r_reg.state != eqac_pkg::EQAC_ST_WAIT);
    assign tif.code = r_reg.wait_code;

    eqac_step_timer #(
        .WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        r_next = r_reg;

        // Synchronisers; first stage feeds only the second
        r_next.sync1 = {remote_selftest_raw, rx_lock_raw};
        r_next.sync2 = r_reg.sync1;
        r_next.sync3 = r_reg.sync2;
        for (int i = 0; i < 2; i++) begin
            // Accept a level once two stages agree
            if (r_reg.sync2[i] == r_reg.sync3[i]) begin
                r_next.filt[i] = r_reg.sync2[i];
            end
        end

        // Register writes
        if (wr_take) begin
            if (hit(paddr, `EQAC_IDX_CTL2)) begin
                r_next.wait_code = pwdata[`EQAC_CTL2_WAIT_LSB +: 3];
                r_next.first_lock_mode = pwdata[`EQAC_CTL2_FIRSTLOCK];
                r_next.floor_en = pwdata[`EQAC_CTL2_FLOOR];
            end
            if (hit(paddr, `EQAC_IDX_BYPASS)) begin
                r_next.man_high = pwdata[`EQAC_BYP_HIGH_LSB +: 3];
                r_next.lock_mode = pwdata[`EQAC_BYP_LOCKMODE];
                r_next.man_low = pwdata[`EQAC_BYP_LOW_LSB +: 3];
                r_next.adapt_dis = pwdata[`EQAC_BYP_DISABLE];
            end
            if (hit(paddr, `EQAC_IDX_MINMAX)) begin
                r_next.cap = pwdata[`EQAC_MM_CAP_LSB +: 4];
                r_next.floor_val = pwdata[`EQAC_MM_FLOOR_LSB +: 4];
            end
        end

        // Adaptation sequencer
        unique case (r_reg.state)
            eqac_pkg::EQAC_ST_BYPASS: begin
                // Manual value from the two fields
                r_next.setting = {r_reg.man_high, r_reg.man_low};
                if (!r_reg.adapt_dis) begin
                    r_next.state = eqac_pkg::EQAC_ST_START;
                end
            end
            eqac_pkg::EQAC_ST_START: begin
                // Load the starting point and begin waiting
                r_next.setting = start_value;
                r_next.zero_start = 1'b0;
                r_next.state = eqac_pkg::EQAC_ST_WAIT;
            end
            eqac_pkg::EQAC_ST_WAIT: begin
                if (lock_now) begin
                    if (r_reg.first_lock_mode && !r_reg.first_lock_seen) begin
                        // First lock discarded; redo from zero
                        r_next.first_lock_seen = 1'b1;
                        r_next.zero_start = 1'b1;
                        r_next.state = eqac_pkg::EQAC_ST_START;
                    end else begin
                        // Lock accepted at the current setting
                        r_next.first_lock_seen = 1'b1;
                        r_next.state = eqac_pkg::EQAC_ST_LOCKED;
                    end
                end else if (tif.expired) begin
                    if (r_reg.setting >= cap_value) begin
                        // Ceiling reached; sweep again from the start
                        r_next.state = eqac_pkg::EQAC_ST_START;
                    end else begin
                        // No lock in time; one step up
                        r_next.setting = r_reg.setting + 6'h01;
                    end
                end
            end
            eqac_pkg::EQAC_ST_LOCKED: begin
                // Lost lock starts a fresh adaptation
                if (!lock_now) begin
                    r_next.state = eqac_pkg::EQAC_ST_START;
                end
            end
        endcase

        // Restart request consumed at once; a new write wins over clear
        if (r_reg.restart_pend) begin
            r_next.restart_pend = 1'b0;
            r_next.first_lock_seen = 1'b0;
            r_next.zero_start = 1'b0;
            r_next.state = eqac_pkg::EQAC_ST_START;
        end
        if (wr_take && hit(paddr, `EQAC_IDX_CTL2) && pwdata[`EQAC_CTL2_RESTART]) begin
            r_next.restart_pend = 1'b1;
        end

        // Bypass overrides everything, taking effect next cycle
        if (r_reg.adapt_dis) begin
            r_next.state = eqac_pkg::EQAC_ST_BYPASS;
            r_next.setting = {r_reg.man_high, r_reg.man_low};
        end

        // Reported lock, optionally gated by adaptation done or bypass
        if (r_reg.lock_mode) begin
            r_next.rlock = lock_now && (r_reg.state == eqac_pkg::EQAC_ST_LOCKED ||
                                        r_reg.state == eqac_pkg::EQAC_ST_BYPASS);
        end else begin
            r_next.rlock = lock_now;
        end

        // Read data captured during setup; reserved bits read zero
        if (setup) begin
            r_next.prdata = 32'h0000_0000;
            if (hit(paddr, `EQAC_IDX_DEBUG)) begin
                r_next.prdata[`EQAC_DEBUG_SELFTEST] = selftest_now;
            end
            if (hit(paddr, `EQAC_IDX_CTL2)) begin
                r_next.prdata[`EQAC_CTL2_WAIT_LSB +: 3] = r_reg.wait_code;
                r_next.prdata[`EQAC_CTL2_FIRSTLOCK] = r_reg.first_lock_mode;
                r_next.prdata[`EQAC_CTL2_RESTART] = r_reg.restart_pend;
                r_next.prdata[`EQAC_CTL2_FLOOR] = r_reg.floor_en;
            end
            if (hit(paddr, `EQAC_IDX_STATUS)) begin
                r_next.prdata[5:0] = r_reg.setting;
            end
            if (hit(paddr, `EQAC_IDX_BYPASS)) begin
                r_next.prdata[`EQAC_BYP_HIGH_LSB +: 3] = r_reg.man_high;
                r_next.prdata[`EQAC_BYP_LOCKMODE] = r_reg.lock_mode;
                r_next.prdata[`EQAC_BYP_LOW_LSB +: 3] = r_reg.man_low;
                r_next.prdata[`EQAC_BYP_DISABLE] = r_reg.adapt_dis;
            end
            if (hit(paddr, `EQAC_IDX_MINMAX)) begin
                r_next.prdata[`EQAC_MM_CAP_LSB +: 4] = r_reg.cap;
                r_next.prdata[`EQAC_MM_FLOOR_LSB +: 4] = r_reg.floor_val;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset loads field defaults; the sequencer starts fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.wait_code <= 3'h4;
            r_reg.floor_en <= 1'b1;
            r_reg.man_high <= 3'h3;
            r_reg.man_low <= 3'h0;
            r_reg.cap <= 4'hF;
            r_reg.floor_val <= 4'h8;
            r_reg.setting <= 6'h00;
            r_reg.state <= eqac_pkg::EQAC_ST_START;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign eq_setting = r_reg.setting;
    assign rx_lock_reported = r_reg.rlock;
    assign adapt_done = (r_reg.state == eqac_pkg::EQAC_ST_LOCKED);

endmodule : eqac_top

`default_nettype wire

// ===== hdl/eqac_regs.svh
/*
 * Register map, field positions, reset values and timing constants
 * for the equalizer adaptation control block.
 * Assumes an APB slave with 32-bit data and one aligned word per register.
 */
`ifndef EQAC_REGS_SVH
`define EQAC_REGS_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define EQAC_IDX_DEBUG 8'hD0
`define EQAC_IDX_CTL2 8'hD2
`define EQAC_IDX_STATUS 8'hD3
`define EQAC_IDX_BYPASS 8'hD4
`define EQAC_IDX_MINMAX 8'hD5

// ****************************************************************
// Reset values
// ****************************************************************
`define EQAC_RST_CTL2 8'h84
`define EQAC_RST_BYPASS 8'h60
`define EQAC_RST_MINMAX 8'hF8

// ****************************************************************
// Field positions
// ****************************************************************
`define EQAC_DEBUG_SELFTEST 5
`define EQAC_CTL2_WAIT_LSB 5
`define EQAC_CTL2_FIRSTLOCK 4
`define EQAC_CTL2_RESTART 3
`define EQAC_CTL2_FLOOR 2
`define EQAC_BYP_HIGH_LSB 5
`define EQAC_BYP_LOCKMODE 4
`define EQAC_BYP_LOW_LSB 1
`define EQAC_BYP_DISABLE 0
`define EQAC_MM_CAP_LSB 4
`define EQAC_MM_FLOOR_LSB 0

// ****************************************************************
// Timing: shortest step wait, doubled per code step
// ****************************************************************
`define EQAC_WAIT_BASE_NS 164000
`define EQAC_CLK_PERIOD_NS 10
`define EQAC_WAIT_BASE_CYCLES ((`EQAC_WAIT_BASE_NS + `EQAC_CLK_PERIOD_NS - 1) / `EQAC_CLK_PERIOD_NS)
`define EQAC_TMR_W 24

`endif

// ===== hdl/eqac_pkg.sv
/*
 * Types for the equalizer adaptation control block.
 * Assumes eqac_regs.svh is on the include path.
 */
`include "eqac_regs.svh"

package eqac_pkg;

    // ****************************************************************
    // Adaptation sequencer states, one-hot
    // ****************************************************************
    typedef enum logic [3:0] {
        EQAC_ST_BYPASS = 4'h1,  // Manual setting in force
        EQAC_ST_START = 4'h2,   // Load starting setting
        EQAC_ST_WAIT = 4'h4,    // Wait for lock at a setting
        EQAC_ST_LOCKED = 4'h8   // Adaptation complete
    } eqac_state_type;

    // ****************************************************************
    // Whole state of the top module
    // ****************************************************************
    typedef struct packed {
        logic [1:0] sync1;           // First stage, bit1 self-test, bit0 lock
        logic [1:0] sync2;           // Second stage
        logic [1:0] sync3;           // Third stage
        logic [1:0] filt;            // Accepted input levels
        logic [2:0] wait_code;       // Step wait selector
        logic first_lock_mode;       // Restart at zero on first lock
        logic floor_en;              // Start from floor value
        logic restart_pend;          // Restart request, self-clearing
        logic adapt_dis;             // Manual bypass
        logic [2:0] man_high;        // Manual setting bits 5..3
        logic lock_mode;             // Lock waits for adaptation
        logic [2:0] man_low;         // Manual setting bits 2..0
        logic [3:0] cap;             // Highest adaptive setting
        logic [3:0] floor_val;       // Floor starting setting
        logic [5:0] setting;         // Current equalizer setting
        eqac_state_type state;       // Sequencer state
        logic first_lock_seen;       // First lock already handled
        logic zero_start;            // Next start forced to zero
        logic rlock;                 // Reported lock
        logic [31:0] prdata;         // Captured read data
    } eqac_top_state_type;

    // ****************************************************************
    // Whole state of the step timer
    // ****************************************************************
    typedef struct packed {
        logic [`EQAC_TMR_W-1:0] count;  // Cycles spent at this step
        logic expired;                  // One-cycle expiry pulse
    } eqac_tmr_state_type;

endpackage : eqac_pkg

// ===== hdl/eqac_tmr_if.sv
/*
 * Carrier between the sequencer and its step timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface eqac_tmr_if;
    logic hold;        // Keep timer cleared
    logic [2:0] code;  // Wait selector
    logic expired;     // One-cycle pulse at end of wait

    modport ctrl (output hold, output code, input expired);
    modport tmr (input hold, input code, output expired);
endinterface : eqac_tmr_if

`default_nettype wire

// ===== hdl/eqac_step_timer.sv
/*
 * Step wait timer: pulses once every base << code cycles while running.
 * Assumes a single clock and the carrier interface eqac_tmr_if.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eqac_regs.svh"

module eqac_step_timer #(
    parameter int unsigned WAIT_BASE_CYCLES = `EQAC_WAIT_BASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    eqac_tmr_if.tmr tif
);

    // Longest wait must fit the counter
    initial begin
        if (WAIT_BASE_CYCLES < 1 || (64'(WAIT_BASE_CYCLES) << 7) >= (64'd1 << `EQAC_TMR_W)) begin
            $error("eqac_step_timer: WAIT_BASE_CYCLES out of range");
        end
    end

    eqac_pkg::eqac_tmr_state_type r_reg;
    eqac_pkg::eqac_tmr_state_type r_next;
    logic [`EQAC_TMR_W-1:0] limit;  // Cycles of one step

    // Doubling per code keeps the divider to a shift
    assign limit = `EQAC_TMR_W'(WAIT_BASE_CYCLES) << tif.code;

    // ****************************************************************
    // Counting
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        r_next.expired = 1'b0;
        if (tif.hold) begin
            // Held cleared outside the wait state
            r_next.count = '0;
        end else if (r_reg.count == limit - `EQAC_TMR_W'(1)) begin
            // Reload so each step waits the full time again
            r_next.count = '0;
            r_next.expired = 1'b1;
        end else begin
            r_next.count = r_reg.count + `EQAC_TMR_W'(1);
        end
    end

    // Registered state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tif.expired = r_reg.expired;

endmodule : eqac_step_timer

`default_nettype wire

// ===== tb/eqac_top_assertions.sv
/* Port checks for eqac_top.
   Assumes it is bound into eqac_top and shadows only APB writes. */
`timescale 1ns/1ps
`default_nettype none
module eqac_chk #(
    parameter int unsigned WAIT_BASE_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_lock_raw,
    input wire logic remote_selftest_raw,
    input wire logic [5:0] eq_setting,
    input wire logic rx_lock_reported,
    input wire logic adapt_done
);
    // ****************
    // Shadow state
    // ****************
    logic wr;
    logic chg;
    logic stepped; // Last change was a plain step
    logic [2:0] wage; // Cycles since any write
    logic [31:0] cnt; // Cycles since last change
    logic [5:0] last_set;
    logic [5:0] start_v;
    logic [7:0] ctl_sh;
    logic [7:0] byp_sh;
    logic [7:0] mm_sh;
    assign wr = psel && penable && pwrite;
    assign chg = eq_setting != last_set;
    assign start_v = !ctl_sh[2] ? 6'h00 : (mm_sh[3:0] > mm_sh[7:4]) ? {2'h0, mm_sh[7:4]} : {2'h0, mm_sh[3:0]};
    // Writes reset wage so restarts never pose as steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_sh <= 8'h84;
            byp_sh <= 8'h60;
            mm_sh <= 8'hF8;
            wage <= 3'h0;
            cnt <= 32'h0;
            last_set <= 6'h00;
            stepped <= 1'b0;
        end else begin
            ctl_sh <= (wr && paddr == 12'h348) ? pwdata[7:0] : ctl_sh;
            byp_sh <= (wr && paddr == 12'h350) ? pwdata[7:0] : byp_sh;
            mm_sh <= (wr && paddr == 12'h354) ? pwdata[7:0] : mm_sh;
            wage <= wr ? 3'h0 : (wage == 3'h7) ? wage : wage + 3'h1;
            cnt <= chg ? 32'h1 : cnt + 32'h1;
            last_set <= eq_setting;
            stepped <= chg ? (eq_setting == last_set + 6'h01 && wage >= 3'h6) : stepped;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait;
        chg && stepped && !byp_sh[0] && eq_setting == last_set + 6'h01 |-> cnt == (WAIT_BASE_CYCLES << ctl_sh[7:5]);
    endproperty
    a_wait: assert property (p_wait) else $error("step interval wrong");
    property p_step;
        chg && !byp_sh[0] && wage == 3'h7 |-> eq_setting == last_set + 6'h01 || eq_setting == start_v || eq_setting == 6'h00;
    endproperty
    a_step: assert property (p_step) else $error("bad setting change");
    property p_cap;
        chg && !byp_sh[0] && wage == 3'h7 |-> eq_setting <= {2'h0, mm_sh[7:4]};
    endproperty
    a_cap: assert property (p_cap) else $error("setting above cap");
    property p_manual;
        byp_sh[0] && wage >= 3'h2 |-> eq_setting == {byp_sh[7:5], byp_sh[3:1]};
    endproperty
    a_manual: assert property (p_manual) else $error("manual setting wrong");
    property p_bypass;
        byp_sh[0] && wage >= 3'h2 |-> !adapt_done;
    endproperty
    a_bypass: assert property (p_bypass) else $error("adapting while bypassed");
    property p_restart;
        wr && paddr == 12'h348 && pwdata[3] && !byp_sh[0] |-> ##[1:4] !adapt_done ##[0:2] eq_setting == start_v;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not seen");
    property p_lock;
        byp_sh[4] && !byp_sh[0] && wage == 3'h7 && rx_lock_reported |-> adapt_done || $past(adapt_done);
    endproperty
    a_lock: assert property (p_lock) else $error("lock before adaptation");
    property p_status;
        psel && penable && !pwrite && paddr == 12'h34C |-> prdata == {26'h0, $past(eq_setting)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_debug;
        psel && penable && !pwrite && paddr == 12'h340 |-> prdata[31:6] == 26'h0 && prdata[4:0] == 5'h00;
    endproperty
    a_debug: assert property (p_debug) else $error("debug reserved bits set");
    c_step: cover property (chg && stepped);
    c_lock: cover property (adapt_done && rx_lock_reported);
    c_manual: cover property (byp_sh[0] && wage == 3'h7);
endmodule : eqac_chk
bind eqac_top eqac_chk #(.WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)) eqac_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_lock_raw(rx_lock_raw),
    .remote_selftest_raw(remote_selftest_raw), .eq_setting(eq_setting),
    .rx_lock_reported(rx_lock_reported), .adapt_done(adapt_done)
);
`default_nettype wire

// ===== tb/eqac_ser_model.sv
/* Remote serializer stand-in: lock and self-test levels.
   Assumes the bench commands both levels. */
`timescale 1ns/1ps
`default_nettype none
module eqac_ser_model (
    input wire logic pclk,
    input wire logic lock_cmd,
    input wire logic selftest_cmd,
    output logic rx_lock_raw,
    output logic remote_selftest_raw
);
    initial rx_lock_raw = 1'b0;
    initial remote_selftest_raw = 1'b0;
    // Levels move 3 ns off the edge, as from a foreign clock
    always @(posedge pclk) begin
        rx_lock_raw <= #3 lock_cmd;
        remote_selftest_raw <= #3 selftest_cmd;
    end
endmodule : eqac_ser_model
`default_nettype wire

// ===== tb/tb_top.sv
/* Self-checking bench for eqac_top.
   Assumes the design and the serializer model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic lock_cmd = 1'b0;
    logic st_cmd = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_lock_raw;
    logic remote_selftest_raw;
    logic [5:0] eq_setting;
    logic rx_lock_reported;
    logic adapt_done;
    int errors = 0;
    int check_count = 0;
    int n;
    logic [31:0] rd;
    logic serr;
    logic [5:0] f;
    logic [2:0] c;
    logic [11:0] adr_tab [4] = '{12'h340, 12'h348, 12'h350, 12'h354};
    logic [31:0] rst_tab [4] = '{32'h00, 32'h84, 32'h60, 32'hF8};
    always #5 pclk = ~pclk;
    eqac_top #(.WAIT_BASE_CYCLES(4)) eqac_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_lock_raw(rx_lock_raw),
        .remote_selftest_raw(remote_selftest_raw), .eq_setting(eq_setting),
        .rx_lock_reported(rx_lock_reported), .adapt_done(adapt_done)
    );
    eqac_ser_model eqac_ser_model_inst (.pclk(pclk), .lock_cmd(lock_cmd), .selftest_cmd(st_cmd),
        .rx_lock_raw(rx_lock_raw), .remote_selftest_raw(remote_selftest_raw));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Cycles spent at one step for a wait code, with a bench base of four
    function automatic logic [31:0] wait_len(input logic [2:0] code);
        return 32'h4 << code;
    endfunction : wait_len
    task end_sim;
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // One APB transfer; held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk(pready, 1'b1);
            end_sim();
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wait_eq(input logic [5:0] e);
        n = 0;
        while (eq_setting !== e && n < 600) begin
            @(posedge pclk);
            n++;
        end
        chk(eq_setting, e);
        if (n >= 600) end_sim();
    endtask : wait_eq
    initial begin
        void'($urandom(88106));
        repeat (8) @(posedge pclk);
        chk(eq_setting, 6'h00);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, adr_tab[i], 32'h0);
            chk(rd, rst_tab[i]);
        end
        apb(1'b0, 12'h344, 32'h0);
        chk(serr, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h340, 32'hFFFFFFFF);
        apb(1'b0, 12'h340, 32'h0);
        chk(rd, 32'h0);
        // Sweep 8..10 then wrap
        apb(1'b1, 12'h354, 32'hA8);
        apb(1'b1, 12'h348, 32'h0C);
        repeat (4) @(posedge pclk);
        wait_eq(6'h09);
        wait_eq(6'h0A);
        wait_eq(6'h08);
        c = 3'($urandom);
        apb(1'b1, 12'h348, {24'h0, c, 5'h0C});
        repeat (4) @(posedge pclk);
        wait_eq(6'h09);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (eq_setting !== 6'h0A && n < 600);
        chk(n, wait_len(c));
        apb(1'b1, 12'h348, 32'hE8);
        wait_eq(6'h00);
        f = 6'(1 + $urandom % 9);
        apb(1'b1, 12'h354, {24'h0, 4'hA, f[3:0]});
        apb(1'b1, 12'h348, 32'hEC);
        wait_eq(f);
        apb(1'b0, 12'h34C, 32'h0);
        chk(rd, {26'h0, f});
        for (int i = 0; i < 3; i++) begin
            f = 6'($urandom);
            apb(1'b1, 12'h350, {24'h0, f[5:3], 1'b0, f[2:0], 1'b1});
            wait_eq(f);
        end
        repeat (100) @(posedge pclk);
        chk({adapt_done, eq_setting}, {1'b0, f});
        // Gated lock with first-lock restart
        apb(1'b1, 12'h354, 32'hA8);
        apb(1'b1, 12'h350, 32'h10);
        apb(1'b1, 12'h348, 32'h1C);
        wait_eq(6'h09);
        lock_cmd <= 1'b1;
        wait_eq(6'h00);
        repeat (12) @(posedge pclk);
        chk({adapt_done, rx_lock_reported, eq_setting}, 8'hC0);
        apb(1'b1, 12'h348, 32'h0C);
        @(posedge pclk);
        apb(1'b0, 12'h348, 32'h0);
        chk(rd, 32'h04);
        repeat (10) @(posedge pclk);
        chk({adapt_done, eq_setting}, 7'h48);
        apb(1'b1, 12'h348, 32'h04);
        repeat (8) @(posedge pclk);
        chk(adapt_done, 1'b1);
        lock_cmd <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(rx_lock_reported, 1'b0);
        st_cmd <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h340, 32'h0);
        chk(rd, 32'h20);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
